// *** verilog/sensor_status_pkg.sv ***
// shared constants and carrier types for the inductive sensor status block
package sensor_status_pkg;

   // register offsets
   localparam logic [7:0] ADDR_LIMIT_BASE  = 8'h10;
   localparam logic [7:0] ADDR_LIMIT_LAST  = 8'h17;
   localparam logic [7:0] ADDR_LOWEST_FREQ = 8'h18;
   localparam logic [7:0] ADDR_MODE        = 8'h19;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h1a;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1b;
   localparam logic [7:0] ADDR_STATUS      = 8'h20;
   localparam logic [7:0] ADDR_LOSS_LO     = 8'h21;
   localparam logic [7:0] ADDR_LOSS_HI     = 8'h22;
   localparam logic [7:0] ADDR_INDUCT_LO   = 8'h23;
   localparam logic [7:0] ADDR_INDUCT_HI   = 8'h24;

   // measurement_status field positions
   localparam int ST_OSC_LOST   = 7;
   localparam int ST_NEW_N      = 6;
   localparam int ST_LOSS_UPPER = 5;
   localparam int ST_LOSS_HYST  = 4;
   localparam int ST_IND_UPPER  = 3;
   localparam int ST_IND_HYST   = 2;
   localparam int ST_POR_BUSY   = 0;

   // interrupt status and mask field positions
   localparam int IRQ_NEW_SAMPLE = 0;
   localparam int IRQ_OSC_LOST   = 1;
   localparam int IRQ_LOSS_UPPER = 2;
   localparam int IRQ_IND_UPPER  = 3;
   localparam int IRQ_BITS       = 4;

   // mode register field
   localparam int MODE_ACTIVE = 0;

   // reset values
   localparam logic [7:0]          RST_LOWEST_FREQ = 8'h00;
   localparam logic [7:0]          RST_LIMIT_BYTE  = 8'h00;
   localparam logic [IRQ_BITS-1:0] RST_IRQ_MASK    = 4'h0;

   // timing: power-on reset busy window
   localparam int CLOCK_HZ     = 50_000_000;
   localparam int POR_TIME_NS  = 2000;
   localparam int POR_CYCLES   = (POR_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int POR_CNT_W    = 8;

   // oscillation watchdog: timeout is the inverted frequency code shifted left by this many bits
   localparam int OSC_STEP_SHIFT = 4;
   localparam int OSC_CNT_W      = 12;

   localparam int N_LIMITS = 8;
   localparam int N_CH     = 2;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] loss;
      logic [15:0] induct;
   } sample_t;

endpackage

// *** verilog/threshold_compare.sv ***
// one channel of latched upper-threshold and hysteresis comparison
`timescale 1ns/1ps
module threshold_compare
   import sensor_status_pkg::*;
#(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // sample and limits
   input  wire logic         sample,
   input  wire logic [W-1:0] result,
   input  wire logic [W-1:0] upper_limit,
   input  wire logic [W-1:0] lower_limit,
   // status read releases the latch
   input  wire logic         release_latch,
   // flags
   output logic              upper_flag_n,
   output logic              hyst_flag,
   output logic              exceed
);

   typedef struct packed {
      logic upper_n;
      logic hyst;
   } cmp_state_t;

   cmp_state_t q;
   cmp_state_t d;

   assign exceed       = sample && (result > upper_limit);
   assign upper_flag_n = q.upper_n;
   assign hyst_flag    = q.hyst;

   always_comb begin
      d = q;
      // a new exceed beats the release in the same cycle
      if (release_latch) begin
         d.upper_n = 1'b1;
      end
      if (exceed) begin
         d.upper_n = 1'b0;
      end
      if (sample) begin
         if (result < lower_limit) begin
            d.hyst = 1'b0;
         end else if (result > upper_limit) begin
            d.hyst = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q <= '{upper_n: 1'b1, hyst: 1'b0};
      end else begin
         q <= d;
      end
   end

endmodule

// *** verilog/inductive_sensor_status.sv ***
// status register, modes and register port of the inductive sensor converter
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module inductive_sensor_status
   import sensor_status_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // register port
   input  wire reg_req_t   req,
   output logic [7:0]      rdata,
   // conversion engine
   input  wire sample_t    sample_in,
   output logic            conv_enable,
   // sensor oscillation pin
   input  wire logic       sensor_osc,
   // interrupt
   output logic            irq
);

   typedef struct packed {
      logic [POR_CNT_W-1:0]        por_cnt;
      logic                        por_busy;
      logic                        active;
      logic [N_LIMITS-1:0][7:0]    limits;
      logic [7:0]                  lowest_freq;
      logic [IRQ_BITS-1:0]         irq_mask;
      logic [IRQ_BITS-1:0]         irq_status;
      logic [2:0]                  osc_sync;
      logic [OSC_CNT_W-1:0]        osc_cnt;
      logic                        osc_lost;
      logic                        new_n;
      logic [15:0]                 loss_result;
      logic [15:0]                 induct_result;
      logic [7:0]                  rdata;
   } state_t;

   localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);

   state_t q;
   state_t d;

   // comparator wiring
   logic [N_CH-1:0][15:0] ch_result;
   logic [N_CH-1:0]       ch_upper_n;
   logic [N_CH-1:0]       ch_hyst;
   logic [N_CH-1:0]       ch_exceed;
   logic                  take_sample;
   logic                  status_read;
   logic [7:0]            status_byte;
   logic [OSC_CNT_W-1:0]  osc_limit;
   logic                  osc_edge;
   logic                  cfg_write;

   assign ch_result[0] = sample_in.loss;
   assign ch_result[1] = sample_in.induct;

   // results only count while converting
   assign take_sample = sample_in.valid && q.active && !q.por_busy;
   assign status_read = req.rd && (req.addr == ADDR_STATUS);

   genvar ch;
   generate
      for (ch = 0; ch < N_CH; ch++) begin : g_cmp
         threshold_compare #(
            .W (16)
         ) u_cmp (
            .clock         (clock),
            .rst           (rst),
            .sample        (take_sample),
            .result        (ch_result[ch]),
            .upper_limit   ({q.limits[ch*4+1], q.limits[ch*4]}),
            .lower_limit   ({q.limits[ch*4+3], q.limits[ch*4+2]}),
            .release_latch (status_read),
            .upper_flag_n  (ch_upper_n[ch]),
            .hyst_flag     (ch_hyst[ch]),
            .exceed        (ch_exceed[ch])
         );
      end
   endgenerate

   // status byte assembly
   always_comb begin
      status_byte                = 8'h00;
      status_byte[ST_OSC_LOST]   = q.osc_lost;
      status_byte[ST_NEW_N]      = q.new_n;
      status_byte[ST_LOSS_UPPER] = ch_upper_n[0];
      status_byte[ST_LOSS_HYST]  = ch_hyst[0];
      status_byte[ST_IND_UPPER]  = ch_upper_n[1];
      status_byte[ST_IND_HYST]   = ch_hyst[1];
      status_byte[ST_POR_BUSY]   = q.por_busy;
   end

   // higher frequency code gives a shorter watchdog, so a code set too high trips it
   assign osc_limit = OSC_CNT_W'({~q.lowest_freq, {OSC_STEP_SHIFT{1'b0}}});
   assign osc_edge  = q.osc_sync[1] && !q.osc_sync[2];

   // writes during power-on reset are dropped
   assign cfg_write = req.wr && !q.por_busy;

   always_comb begin
      logic [IRQ_BITS-1:0] ev;
      logic [IRQ_BITS-1:0] clr;
      logic                lost_now;
      ev       = '0;
      clr      = '0;
      lost_now = 1'b0;
      d        = q;

      // power-on busy window
      if (q.por_busy) begin
         if (q.por_cnt == POR_LAST) begin
            d.por_busy = 1'b0;
         end else begin
            d.por_cnt = q.por_cnt + 1'b1;
         end
      end

      // oscillation watchdog, pin synchronised first
      d.osc_sync = {q.osc_sync[1:0], sensor_osc};
      if (!q.active || osc_edge) begin
         d.osc_cnt  = '0;
         d.osc_lost = 1'b0;
      end else if (q.osc_cnt >= osc_limit) begin
         lost_now   = 1'b1;
         d.osc_lost = 1'b1;
      end else begin
         d.osc_cnt = q.osc_cnt + 1'b1;
      end

      // reading status consumes the new-sample indication; new data wins
      if (status_read) begin
         d.new_n = 1'b1;
      end
      if (take_sample) begin
         d.new_n         = 1'b0;
         d.loss_result   = sample_in.loss;
         d.induct_result = sample_in.induct;
      end

      // configuration writes
      if (cfg_write) begin
         if (req.addr >= ADDR_LIMIT_BASE && req.addr <= ADDR_LIMIT_LAST) begin
            d.limits[req.addr[2:0]] = req.wdata;
         end
         case (req.addr)
            ADDR_LOWEST_FREQ: d.lowest_freq = req.wdata;
            ADDR_MODE:        d.active      = req.wdata[MODE_ACTIVE];
            ADDR_IRQ_MASK:    d.irq_mask    = req.wdata[IRQ_BITS-1:0];
            ADDR_IRQ_STATUS:  clr           = req.wdata[IRQ_BITS-1:0];
            default: ;
         endcase
      end

      // sticky events, set beats write-one-to-clear
      ev[IRQ_NEW_SAMPLE] = take_sample;
      ev[IRQ_OSC_LOST]   = lost_now && !q.osc_lost;
      ev[IRQ_LOSS_UPPER] = ch_exceed[0];
      ev[IRQ_IND_UPPER]  = ch_exceed[1];
      d.irq_status = (q.irq_status & ~clr) | ev;

      // read data, one cycle after the strobe
      d.rdata = 8'h00;
      if (req.rd) begin
         if (req.addr >= ADDR_LIMIT_BASE && req.addr <= ADDR_LIMIT_LAST) begin
            d.rdata = q.limits[req.addr[2:0]];
         end
         case (req.addr)
            ADDR_LOWEST_FREQ: d.rdata = q.lowest_freq;
            ADDR_MODE:        d.rdata = {7'h00, q.active};
            ADDR_IRQ_STATUS:  d.rdata = {4'h0, q.irq_status};
            ADDR_IRQ_MASK:    d.rdata = {4'h0, q.irq_mask};
            ADDR_STATUS:      d.rdata = status_byte;
            ADDR_LOSS_LO:     d.rdata = q.loss_result[7:0];
            ADDR_LOSS_HI:     d.rdata = q.loss_result[15:8];
            ADDR_INDUCT_LO:   d.rdata = q.induct_result[7:0];
            ADDR_INDUCT_HI:   d.rdata = q.induct_result[15:8];
            default:          ;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q.por_cnt       <= '0;
         q.por_busy      <= 1'b1;
         q.active        <= 1'b0;
         q.limits        <= {N_LIMITS{RST_LIMIT_BYTE}};
         q.lowest_freq   <= RST_LOWEST_FREQ;
         q.irq_mask      <= RST_IRQ_MASK;
         q.irq_status    <= '0;
         q.osc_sync      <= '0;
         q.osc_cnt       <= '0;
         q.osc_lost      <= 1'b0;
         q.new_n         <= 1'b1;
         q.loss_result   <= 16'h0000;
         q.induct_result <= 16'h0000;
         q.rdata         <= 8'h00;
      end else begin
         q <= d;
      end
   end

   // free-running conversion while active and out of reset
   assign conv_enable = q.active && !q.por_busy;
   assign irq         = |(q.irq_status & q.irq_mask);
   assign rdata       = q.rdata;

endmodule

// *** bench/status_chk.sv ***
// port-level assertions for the inductive sensor status block
`timescale 1ns/1ps
module status_chk
   import sensor_status_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst,
   input wire reg_req_t   req,
   input wire logic [7:0] rdata,
   input wire sample_t    sample_in,
   input wire logic       conv_enable,
   input wire logic       sensor_osc,
   input wire logic       irq
);
   logic [7:0] age_q;
   logic       st_rd;
   assign st_rd = req.rd && (req.addr == ADDR_STATUS);
   // saturating edge count since reset release, tracks the busy window
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         age_q <= 8'h00;
      end else if (age_q != 8'hff) begin
         age_q <= age_q + 8'h01;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_rdata_idle_zero: assert property (!$past(req.rd) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (req.rd && req.addr == 8'h30 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_spare_bit_zero: assert property (st_rd |=> !rdata[1])
      else $error("status spare bit set");
   a_por_busy_flag: assert property (st_rd && age_q < 8'd90 |=> rdata[ST_POR_BUSY])
      else $error("busy flag low during reset window");
   a_por_done_flag: assert property (st_rd && age_q > 8'd110 |=> !rdata[ST_POR_BUSY])
      else $error("busy flag high after reset window");
   a_por_no_conv: assert property (age_q < 8'd90 |-> !conv_enable)
      else $error("converting during reset window");
   a_new_sample_low: assert property (sample_in.valid && conv_enable ##1 st_rd
      |=> !rdata[ST_NEW_N])
      else $error("new sample flag not low after sample");
   a_read_releases: assert property (st_rd && !sample_in.valid ##1 !sample_in.valid
      ##1 st_rd && !sample_in.valid
      |=> rdata[ST_NEW_N] && rdata[ST_LOSS_UPPER] && rdata[ST_IND_UPPER])
      else $error("flags not released by status read");
   a_osc_sleep_clear: assert property (st_rd && !conv_enable |=> !rdata[ST_OSC_LOST])
      else $error("oscillation flag set in sleep");
   c_sample: cover property (sample_in.valid && conv_enable);
   c_active_read: cover property (st_rd && conv_enable);
   c_irq_rise: cover property ($rose(irq));
endmodule

bind inductive_sensor_status status_chk u_chk (
   .clock       (clock),
   .rst         (rst),
   .req         (req),
   .rdata       (rdata),
   .sample_in   (sample_in),
   .conv_enable (conv_enable),
   .sensor_osc  (sensor_osc),
   .irq         (irq)
);

// *** bench/engine_model.sv ***
// conversion engine and sensor model facing the status block
`timescale 1ns/1ps
module engine_model
   import sensor_status_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        conv_enable,
   input  wire logic        osc_run,
   input  wire logic [15:0] loss,
   input  wire logic [15:0] induct,
   output sample_t          sample_out,
   output logic             sensor_osc
);
   logic [4:0] tick_q;
   logic [1:0] osc_q;
   logic       fire;
   assign fire = conv_enable && (tick_q == 5'h1f);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tick_q <= 5'h00;
         osc_q <= 2'h0;
         sample_out <= '0;
      end else begin
         tick_q <= conv_enable ? tick_q + 5'h01 : 5'h00;
         // data outside a strobe is inverted so stale values never pass
         sample_out <= '{fire, fire ? loss : ~loss, fire ? induct : ~induct};
         if (osc_run) begin
            osc_q <= osc_q + 2'h1;
         end
      end
   end
   assign sensor_osc = osc_q[1];
endmodule

// *** bench/inductive_sensor_status_tb.sv ***
// self-checking bench for the inductive sensor status block
`timescale 1ns/1ps
module inductive_sensor_status_tb
   import sensor_status_pkg::*;
;
   logic        clock;
   logic        rst;
   reg_req_t    req;
   logic [7:0]  rdata;
   sample_t     smp;
   logic        conv_enable;
   logic        sensor_osc;
   logic        irq;
   logic        osc_run;
   logic [15:0] loss;
   logic [15:0] induct;
   int          err_count = 0;
   int          cmp_count = 0;
   // limits lu=0100 ll=0080 iu=0200 il=0100, then lowest freq (16-cycle watchdog)
   logic [7:0]  cfg [9] = '{8'h00, 8'h01, 8'h80, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01,
                            8'hfe}; // watchdog code chosen for a 50 MHz reference

   inductive_sensor_status u_dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
      .sample_in(smp), .conv_enable(conv_enable), .sensor_osc(sensor_osc), .irq(irq));
   engine_model u_eng (.clock(clock), .rst(rst), .conv_enable(conv_enable), .osc_run(osc_run),
      .loss(loss), .induct(induct), .sample_out(smp), .sensor_osc(sensor_osc));

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bus tasks start and end on a rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      req <= '0;
      @(posedge clock);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      req <= '0;
      @(posedge clock);
      chk(nm, e, rdata & m);
   endtask
   task automatic wait_sample;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (smp.valid !== 1'b1 && n < 40);
      chk("sample_seen", 8'h01, {7'h00, smp.valid});
   endtask
   task automatic t_por;
      rd("por_busy", ADDR_STATUS, 8'h01, 8'h01);
      wr(ADDR_LIMIT_BASE, 8'h5a);
      rd("por_write", ADDR_LIMIT_BASE, 8'hff, 8'h00);
      repeat (100) @(posedge clock);
      rd("por_done", ADDR_STATUS, 8'h01, 8'h00);
      $display("test por done");
   endtask
   task automatic t_map;
      for (int a = 16'h10; a <= 16'h1b; a++) begin
         rd("reset_value", a[7:0], 8'hff, 8'h00);
      end
      for (int a = 16'h21; a <= 16'h24; a++) begin
         rd("result_reset", a[7:0], 8'hff, 8'h00);
      end
      rd("unmapped", 8'h30, 8'hff, 8'h00);
      wr(ADDR_STATUS, 8'h00);
      rd("status_idle", ADDR_STATUS, 8'hff, 8'h68);
      rd("status_again", ADDR_STATUS, 8'hff, 8'h68);
      $display("test map done");
   endtask
   task automatic t_cfg;
      for (int i = 0; i < 9; i++) begin
         wr(ADDR_LIMIT_BASE + i[7:0], cfg[i]);
      end
      for (int i = 0; i < 9; i++) begin
         rd("config", ADDR_LIMIT_BASE + i[7:0], 8'hff, cfg[i]);
      end
      repeat (40) @(posedge clock);
      rd("no_sleep_data", ADDR_STATUS, 8'h40, 8'h40);
      $display("test config done");
   endtask
   task automatic t_active;
      loss <= 16'h0150;
      osc_run <= 1'b1;
      wr(ADDR_MODE, 8'h01);
      chk("conv_on", 8'h01, {7'h00, conv_enable});
      wait_sample;
      rd("first", ADDR_STATUS, 8'hfc, 8'h18);
      rd("loss_lo", ADDR_LOSS_LO, 8'hff, 8'h50);
      rd("loss_hi", ADDR_LOSS_HI, 8'hff, 8'h01);
      rd("ind_lo", ADDR_INDUCT_LO, 8'hff, 8'h50);
      wait_sample;
      loss <= 16'h0090;
      wait_sample;
      rd("latched", ADDR_STATUS, 8'h30, 8'h10);
      wait_sample;
      rd("released", ADDR_STATUS, 8'h30, 8'h30);
      loss <= 16'h0070;
      wait_sample;
      rd("loss_low", ADDR_STATUS, 8'h30, 8'h20);
      induct <= 16'h0250;
      wait_sample;
      rd("ind_high", ADDR_STATUS, 8'h0c, 8'h04);
      rd("ind_hi", ADDR_INDUCT_HI, 8'hff, 8'h02);
      induct <= 16'h0150;
      wait_sample;
      wait_sample;
      rd("ind_hold", ADDR_STATUS, 8'h0c, 8'h0c);
      $display("test active done");
   endtask
   task automatic t_osc;
      rd("osc_ok", ADDR_STATUS, 8'h80, 8'h00);
      osc_run <= 1'b0;
      repeat (40) @(posedge clock);
      rd("osc_lost", ADDR_STATUS, 8'h80, 8'h80);
      osc_run <= 1'b1;
      repeat (20) @(posedge clock);
      rd("osc_back", ADDR_STATUS, 8'h80, 8'h00);
      $display("test oscillation done");
   endtask
   task automatic t_irq;
      wr(ADDR_IRQ_MASK, 8'h01);
      // oscillation, loss and inductance events left sticky by earlier tests
      rd("irq_events", ADDR_IRQ_STATUS, 8'h0e, 8'h0e);
      wait_sample;
      // cleared well inside the sample spacing, so the next event is the sample itself
      wr(ADDR_IRQ_STATUS, 8'h0f);
      chk("irq_idle", 8'h00, {7'h00, irq});
      wait_sample;
      @(posedge clock);
      chk("irq_set", 8'h01, {7'h00, irq});
      wr(ADDR_MODE, 8'h00);
      rd("irq_status", ADDR_IRQ_STATUS, 8'h01, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h00);
      chk("irq_masked", 8'h00, {7'h00, irq});
      wr(ADDR_IRQ_MASK, 8'h01);
      chk("irq_unmasked", 8'h01, {7'h00, irq});
      wr(ADDR_IRQ_STATUS, 8'h0f);
      chk("irq_cleared", 8'h00, {7'h00, irq});
      rd("irq_empty", ADDR_IRQ_STATUS, 8'h0f, 8'h00);
      $display("test interrupt done");
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      req = '0;
      osc_run = 1'b0;
      loss = 16'h0000;
      induct = 16'h0050;
      rst = 1'b1;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_por;
      t_map;
      t_cfg;
      t_active;
      t_osc;
      t_irq;
      wrap_up;
   end
   // whole run needs about 700 cycles
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      $display("mismatch watchdog expected done seen hang");
      wrap_up;
   end
endmodule
